// [rtl/tcp_timer_core.v]
/*
  Timer core: clock select and prescaler, 16-bit wrapping counter,
  overflow flag, coherent counter read, guarded wrap limit, and six
  capture/compare channels, all behind an AXI4-Lite slave.
  Assumes one 10 MHz ref_clk, asynchronous active-low arst_n, and an
  AXI4-Lite master keeping valid and payload stable until taken.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "tcp_timer_defines.vh"

module tcp_timer_core #(
  parameter NCH = 6,
  parameter AW  = 12
) (
  input  wire            ref_clk,
  input  wire            arst_n,
  input  wire [AW-1:0]   s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [AW-1:0]   s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire            external_timer_clock_pin,
  output reg             port_direction_force_in,
  input  wire [NCH-1:0]  ch_pin_in,
  output wire [NCH-1:0]  ch_pin_out,
  output wire [NCH-1:0]  ch_pin_oe_n,
  output reg             overflow_irq,
  output wire [NCH-1:0]  channel_irq,
  output reg  [15:0]     count_value,
  output reg             overflow_pulse
);

  // ----------------------------------------------------------------------
  // bus slave: write and read channels
  // ----------------------------------------------------------------------
  reg  [AW-1:0]  aw_addr_r;
  reg            aw_full_r;
  reg  [31:0]    w_data_r;
  reg  [3:0]     w_strb_r;
  reg            w_full_r;
  reg  [AW-1:0]  ar_addr_r;
  reg            rd_pend_r;
  reg  [31:0]    rd_mux;
  reg            rd_hit;

  wire           wr_do  = aw_full_r && w_full_r && !s_axi_bvalid;
  wire [7:0]     wr_idx = aw_addr_r[9:2];
  wire           wr_ok  = (aw_addr_r[AW-1:10] == {(AW-10){1'b0}});
  wire           wr_b0  = wr_do && wr_ok && w_strb_r[0];
  wire [7:0]     wd     = w_data_r[7:0];
  wire           rd_do  = rd_pend_r;
  wire [7:0]     rd_idx = ar_addr_r[9:2];
  wire           rd_ok  = (ar_addr_r[AW-1:10] == {(AW-10){1'b0}});

  // address and data are taken independently, in either order
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCP_RESP_OKAY;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      aw_addr_r     <= {AW{1'b0}};
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read: address taken, data one cycle later from the mux
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TCP_RESP_OKAY;
      ar_addr_r     <= {AW{1'b0}};
      rd_pend_r     <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_r     <= s_axi_araddr;
        rd_pend_r     <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (rd_do) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg            ext_s1_r;
  reg            ext_s2_r;
  reg            ext_s3_r;
  reg [NCH-1:0]  ch_s1_r;
  reg [NCH-1:0]  ch_s2_r;
  reg [NCH-1:0]  ch_s3_r;

  // first stage is read only by the second; edges use stages two and three
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ch_s1_r  <= {NCH{1'b0}};
      ch_s2_r  <= {NCH{1'b0}};
      ch_s3_r  <= {NCH{1'b0}};
    end else begin
      ext_s1_r <= external_timer_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      ch_s1_r  <= ch_pin_in;
      ch_s2_r  <= ch_s1_r;
      ch_s3_r  <= ch_s2_r;
    end
  end

  wire           ext_rise = ext_s2_r && !ext_s3_r;
  wire [NCH-1:0] ch_rise  = ch_s2_r & ~ch_s3_r;
  wire [NCH-1:0] ch_fall  = ~ch_s2_r & ch_s3_r;

  // ----------------------------------------------------------------------
  // status/control, prescaler and counter
  // ----------------------------------------------------------------------
  reg            ovf_flag_r;
  reg            ovf_arm_r;
  reg            ovf_ie_r;
  reg            halt_r;
  reg  [2:0]     sel_r;
  reg  [6:0]     pre_r;
  reg  [15:0]    cnt_r;
  reg  [15:0]    wrap_r;
  reg            wrap_block_r;
  reg  [7:0]     lo_buf_r;
  reg            lo_latched_r;

  wire           sc_wr    = wr_b0 && (wr_idx == `TCP_IDX_STATUS);
  wire           crst     = sc_wr && wd[`TCP_SC_CRST];
  wire [6:0]     pmask    = ~(7'h7f << sel_r);
  wire           pre_hit  = ((pre_r & pmask) == pmask);
  // tick: prescaler tap or external edge, gated by halt
  wire           tick     = !halt_r && ((sel_r == `TCP_SEL_EXT) ?
                            ext_rise : pre_hit);
  wire [15:0]    cnt_inc  = cnt_r + 16'h0001;
  // wrap to zero on the tick after the limit was reached
  wire [15:0]    cnt_nxt  = (cnt_r == wrap_r) ? 16'h0000 : cnt_inc;
  wire           reach    = tick && !crst && (cnt_nxt == wrap_r);
  // wrap-high write without wrap-low keeps the flag quiet
  wire           ovf_evt  = reach && !wrap_block_r;

  // halt, enable and clock select
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_r   <= 1'b1;
      ovf_ie_r <= 1'b0;
      sel_r    <= 3'h0;
    end else if (sc_wr) begin
      halt_r   <= wd[`TCP_SC_HALT];
      ovf_ie_r <= wd[`TCP_SC_IE];
      sel_r    <= wd[`TCP_SC_SEL_HI:`TCP_SC_SEL_LO];
    end
  end

  // overflow flag: read-while-set arms, write 0 clears, event wins
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_flag_r <= 1'b0;
      ovf_arm_r  <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_r <= 1'b1;
      ovf_arm_r  <= 1'b0;
    end else if (sc_wr && !wd[`TCP_SC_FLAG] && ovf_arm_r) begin
      ovf_flag_r <= 1'b0;
      ovf_arm_r  <= 1'b0;
    end else if (rd_do && rd_ok && rd_idx == `TCP_IDX_STATUS &&
                 ovf_flag_r) begin
      ovf_arm_r  <= 1'b1;
    end
  end

  // prescaler and counter; counter reset overrides a tick
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= 7'h00;
      cnt_r <= `TCP_CNT_RESET;
    end else if (crst) begin
      pre_r <= 7'h00;
      cnt_r <= `TCP_CNT_RESET;
    end else if (!halt_r) begin
      pre_r <= pre_r + 7'h01;
      if (tick)
        cnt_r <= cnt_nxt;
    end
  end

  // wrap limit bytes; high byte write blocks until low byte write
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrap_r       <= `TCP_WRAP_RESET;
      wrap_block_r <= 1'b0;
    end else if (wr_b0 && wr_idx == `TCP_IDX_WRAP_HI) begin
      wrap_r[15:8] <= wd;
      wrap_block_r <= 1'b1;
    end else if (wr_b0 && wr_idx == `TCP_IDX_WRAP_LO) begin
      wrap_r[7:0]  <= wd;
      wrap_block_r <= 1'b0;
    end
  end

  // coherent read: high-byte read freezes the low byte once
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_buf_r     <= 8'h00;
      lo_latched_r <= 1'b0;
    end else if (rd_do && rd_ok) begin
      if (rd_idx == `TCP_IDX_CNT_HI && !lo_latched_r) begin
        lo_buf_r     <= cnt_r[7:0];
        lo_latched_r <= 1'b1;
      end else if (rd_idx == `TCP_IDX_CNT_LO) begin
        lo_latched_r <= 1'b0;
      end
    end
  end

  // registered outputs: irq, pin direction, counter and event
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq            <= 1'b0;
      port_direction_force_in <= 1'b0;
      count_value             <= 16'h0000;
      overflow_pulse          <= 1'b0;
    end else begin
      overflow_irq            <= ovf_ie_r && (ovf_flag_r || ovf_evt);
      port_direction_force_in <= (sel_r == `TCP_SEL_EXT);
      count_value             <= crst ? 16'h0000 :
                                 (tick ? cnt_nxt : cnt_r);
      overflow_pulse          <= reach;
    end
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  wire [8*NCH-1:0]  ch_ctrl_flat;
  wire [16*NCH-1:0] ch_val_flat;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      localparam [31:0] GW = g;
      localparam [7:0]  CI = `TCP_IDX_CH_CTRL0 + GW[7:0];
      localparam [7:0]  VI = `TCP_IDX_CH_VAL0 + GW[7:0];
      reg  [7:0]   ctrl_r;
      reg  [15:0]  val_r;
      reg          arm_r;
      reg          out_r;
      reg          oe_n_r;
      reg          irq_r;
      wire         dis;
      // only even channels hold the buffered bit; it disables the odd one
      if (g % 2 == 1) begin : g_odd
        assign dis = ch_ctrl_flat[8*(g-1)+`TCP_CH_MSB];
      end else begin : g_even
        assign dis = 1'b0;
      end
      wire [1:0]   els  = ctrl_r[`TCP_CH_ELS_HI:`TCP_CH_ELS_LO];
      wire         cmpm = (ctrl_r[`TCP_CH_MSA] || ctrl_r[`TCP_CH_MSB]) && !dis;
      wire         capm = !ctrl_r[`TCP_CH_MSA] && !ctrl_r[`TCP_CH_MSB] &&
                          (els != 2'b00) && !dis;
      // captures ignored while halted
      wire         cap_evt = capm && !halt_r &&
                             ((els[0] && ch_rise[g]) || (els[1] && ch_fall[g]));
      wire         cmp_evt = cmpm && tick && !crst && (cnt_nxt == val_r);
      wire         evt     = cap_evt || cmp_evt;
      wire         ctl_wr  = wr_b0 && (wr_idx == CI);
      wire         val_wr  = wr_do && wr_ok && (wr_idx == VI);
      wire [7:0]   wmask   = (g % 2 == 0) ? 8'h7f : 8'h5f;

      // control bits; flag handled apart, buffered bit masked on odd
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          ctrl_r <= `TCP_CH_RESET;
          arm_r  <= 1'b0;
        end else begin
          if (ctl_wr)
            ctrl_r[6:0] <= wd[6:0] & wmask[6:0];
          if (evt) begin
            ctrl_r[`TCP_CH_FLAG] <= 1'b1;
            arm_r                <= 1'b0;
          end else if (ctl_wr && !wd[`TCP_CH_FLAG] && arm_r) begin
            ctrl_r[`TCP_CH_FLAG] <= 1'b0;
            arm_r                <= 1'b0;
          end else if (rd_do && rd_ok && rd_idx == CI &&
                       ctrl_r[`TCP_CH_FLAG]) begin
            arm_r <= 1'b1;
          end
        end
      end

      // value: software write, or counter snapshot on capture
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          val_r <= `TCP_CH_VAL_RESET;
        end else if (cap_evt) begin
          val_r <= cnt_r;
        end else if (val_wr) begin
          if (w_strb_r[0])
            val_r[7:0]  <= w_data_r[7:0];
          if (w_strb_r[1])
            val_r[15:8] <= w_data_r[15:8];
        end
      end

      // pin: overflow toggle beats compare action; preset when els is 00
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          out_r  <= 1'b1;
          oe_n_r <= 1'b1;
          irq_r  <= 1'b0;
        end else begin
          oe_n_r <= !(cmpm && els != 2'b00);
          irq_r  <= ctrl_r[`TCP_CH_IE] &&
                    (ctrl_r[`TCP_CH_FLAG] || evt);
          if (els == 2'b00)
            out_r <= !ctrl_r[`TCP_CH_MSA];
          else if (cmpm && reach && ctrl_r[`TCP_CH_TOV])
            out_r <= !out_r;
          else if (cmp_evt)
            out_r <= (els == 2'b01) ? !out_r : els[0];
        end
      end

      assign ch_ctrl_flat[8*g +: 8]   = ctrl_r;
      assign ch_val_flat[16*g +: 16]  = val_r;
      assign ch_pin_out[g]            = out_r;
      assign ch_pin_oe_n[g]           = oe_n_r;
      assign channel_irq[g]           = irq_r;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  integer i;
  // counter reset bit always reads 0 counter bytes read-only
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = rd_ok;
    case (rd_idx)
      `TCP_IDX_STATUS:  rd_mux[7:0] = {ovf_flag_r, ovf_ie_r, halt_r,
                                       1'b0, 1'b0, sel_r};
      `TCP_IDX_CNT_HI:  rd_mux[7:0] = cnt_r[15:8];
      `TCP_IDX_CNT_LO:  rd_mux[7:0] = lo_latched_r ? lo_buf_r : cnt_r[7:0];
      `TCP_IDX_WRAP_HI: rd_mux[7:0] = wrap_r[15:8];
      `TCP_IDX_WRAP_LO: rd_mux[7:0] = wrap_r[7:0];
      default: begin
        rd_hit = 1'b0;
        for (i = 0; i < NCH; i = i + 1) begin
          if (rd_idx == `TCP_IDX_CH_CTRL0 + i[7:0]) begin
            rd_mux[7:0] = ch_ctrl_flat[8*i +: 8];
            rd_hit      = rd_ok;
          end
          if (rd_idx == `TCP_IDX_CH_VAL0 + i[7:0]) begin
            rd_mux[15:0] = ch_val_flat[16*i +: 16];
            rd_hit       = rd_ok;
          end
        end
      end
    endcase
    if (!rd_ok)
      rd_mux = 32'h00000000;
  end

endmodule

// [rtl/tcp_timer_defines.vh]
/*
  Register indices, field positions and reset values of the timer core.
  Assumes it is included by its bare name from the timer core module.
*/
`ifndef TCP_TIMER_DEFINES_VH
`define TCP_TIMER_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define TCP_IDX_STATUS     8'h20
`define TCP_IDX_CNT_HI     8'h22
`define TCP_IDX_CNT_LO     8'h23
`define TCP_IDX_WRAP_HI    8'h24
`define TCP_IDX_WRAP_LO    8'h25
`define TCP_IDX_CH_CTRL0   8'h30
`define TCP_IDX_CH_VAL0    8'h38

// ----------------------------------------------------------------------
// timer status/control fields
// ----------------------------------------------------------------------
`define TCP_SC_FLAG        7
`define TCP_SC_IE          6
`define TCP_SC_HALT        5
`define TCP_SC_CRST        4
`define TCP_SC_SEL_HI      2
`define TCP_SC_SEL_LO      0
`define TCP_SEL_EXT        3'h7
`define TCP_SC_RESET       8'h20

// ----------------------------------------------------------------------
// channel status/control fields
// ----------------------------------------------------------------------
`define TCP_CH_FLAG        7
`define TCP_CH_IE          6
`define TCP_CH_MSB         5
`define TCP_CH_MSA         4
`define TCP_CH_ELS_HI      3
`define TCP_CH_ELS_LO      2
`define TCP_CH_TOV         1
`define TCP_CH_MAX         0
`define TCP_CH_RESET       8'h00
`define TCP_CH_VAL_RESET   16'h0000

// ----------------------------------------------------------------------
// counter and bus values
// ----------------------------------------------------------------------
`define TCP_WRAP_RESET     16'hffff
`define TCP_CNT_RESET      16'h0000
`define TCP_RESP_OKAY      2'h0
`define TCP_RESP_SLVERR    2'h2

`endif

// [tb/tcp_timer_core_properties.sv]
/*
  Checker for the timer core: bus handshakes, counter stepping and wrap,
  external pin as the only count source while it is selected.
  Assumes it is bound to tcp_timer_core and sees only its ports.
*/
`timescale 1ns/1ns

module tcp_timer_core_properties (
  input wire        ref_clk,
  input wire        arst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        external_timer_clock_pin,
  input wire        port_direction_force_in,
  input wire [15:0] count_value,
  input wire        overflow_pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  AST_B_LAT: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_R_LAT: assert property (
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  AST_B_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not withdrawn");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not withdrawn");
  // a second address is refused in the cycle after one is taken
  AST_AW_BUSY: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken while busy");

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // pin held still for eight cycles while it is the count source
  sequence s_ext_quiet;
    (port_direction_force_in && $stable(external_timer_clock_pin))[*8];
  endsequence

  AST_CNT_STEP: assert property (
    !$stable(count_value) |-> count_value == 16'h0000 ||
    count_value == $past(count_value) + 16'h0001)
    else $error("counter jumped");
  AST_OVF_WRAP: assert property (
    overflow_pulse |=> $stable(count_value) || count_value == 16'h0000)
    else $error("counter did not restart at zero");
  AST_EXT_ONLY: assert property (
    s_ext_quiet |-> $stable(count_value) || count_value == 16'h0000)
    else $error("counter moved without a pin edge");
endmodule

bind tcp_timer_core tcp_timer_core_properties i_chk (
  .ref_clk(ref_clk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .external_timer_clock_pin(external_timer_clock_pin),
  .port_direction_force_in(port_direction_force_in),
  .count_value(count_value), .overflow_pulse(overflow_pulse)
);

// [tb/tb_timer_core_counter_prescaler.sv]
/*
  Self-checking bench of the timer core: reset values, prescaler,
  external clock, wrap and flag handshakes, coherent read, channels.
  Assumes the design files and the checker are compiled before it.
*/
`timescale 1ns/1ns
`include "tcp_timer_defines.vh"

module tb_timer_core_counter_prescaler;
  localparam [7:0] a_st = `TCP_IDX_STATUS;
  localparam [7:0] a_hi = `TCP_IDX_CNT_HI;
  localparam [7:0] a_wh = `TCP_IDX_WRAP_HI;
  localparam [7:0] a_wl = `TCP_IDX_WRAP_LO;
  localparam [7:0] a_c0 = `TCP_IDX_CH_CTRL0;
  localparam [7:0] a_c1 = `TCP_IDX_CH_CTRL0 + 8'h01;

  reg         ref_clk = 1'b0, arst_n = 1'b0, ext = 1'b0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0] wdata = 32'h00000000, d;
  reg  [15:0] v;
  reg  [5:0]  ch_in = 6'h00;
  wire        awready, wready, bvalid, arready, rvalid, force_in, ovf_irq;
  wire [1:0]  bresp;
  wire [31:0] rdata;
  wire [5:0]  ch_irq;
  wire [15:0] count;
  integer     n_errors = 0, n_tests = 0, s;

  tcp_timer_core i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_timer_clock_pin(ext),
    .port_direction_force_in(force_in), .ch_pin_in(ch_in),
    .ch_pin_out(), .ch_pin_oe_n(), .overflow_irq(ovf_irq),
    .channel_irq(ch_irq), .count_value(count), .overflow_pulse()
  );

  // ------------------------------------------------------------------
  // compare tasks and closing
  // ------------------------------------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  // window compare where bus latency blurs the tick count
  task chkr(input string nm, input [31:0] lo, hi, g);
    begin
      n_tests = n_tests + 1;
      if ((g >= lo && g <= hi) !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s exp %0d..%0d got %h", nm, lo, hi, g);
      end
    end
  endtask

  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // ------------------------------------------------------------------
  // bus tasks: ready is looked at mid-cycle, acted on at the edge
  // ------------------------------------------------------------------
  task wr(input [7:0] idx, input [31:0] wd);
    reg       a, w;
    reg [1:0] r;
    begin
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= wd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      a = 1'b1;
      w = 1'b1;
      while (a | w) begin
        @(negedge ref_clk);
        if (awready) a = 1'b0;
        if (wready) w = 1'b0;
        @(posedge ref_clk);
        if (!a) awvalid <= 1'b0;
        if (!w) wvalid <= 1'b0;
      end
      bready <= 1'b1;
      do begin
        @(negedge ref_clk);
        a = bvalid;
        r = bresp;
        @(posedge ref_clk);
      end while (!a);
      bready <= 1'b0;
      chk("bresp", {30'h0, `TCP_RESP_OKAY}, {30'h0, r});
    end
  endtask

  task rd(input [7:0] idx, output [31:0] rd_d);
    reg a;
    begin
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      do begin
        @(negedge ref_clk);
        a = arready;
        @(posedge ref_clk);
      end while (!a);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
        @(negedge ref_clk);
        a = rvalid;
        rd_d = rdata;
        @(posedge ref_clk);
      end while (!a);
      rready <= 1'b0;
    end
  endtask

  // high byte first, so the low byte comes from the holding buffer
  task rc(output [15:0] cv);
    begin
      rd(a_hi, d);
      cv[15:8] = d[7:0];
      rd(a_hi + 8'h01, d);
      cv[7:0] = d[7:0];
    end
  endtask

  // one pin pulse, four cycles high and four low
  task pulse(input integer k);
    begin
      if (k == 0) ext <= 1'b1;
      else ch_in[1] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext <= 1'b0;
      ch_in[1] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task t_reset;
    begin
      rd(a_st, d); chk("status", `TCP_SC_RESET, d);
      rd(a_wh, d); chk("wrap_hi", 32'h000000ff, d);
      rd(a_wl, d); chk("wrap_lo", 32'h000000ff, d);
      rc(v); chk("count", 32'h0, {16'h0, v});
      rd(a_c0, d); chk("ch_ctrl", `TCP_CH_RESET, d);
      rd(8'h3f, d); chk("unmapped", 32'h0, d);
      $display("reset test done");
    end
  endtask

  task t_latch;
    begin
      wr(a_st, 32'h00000030);
      rd(a_hi, d);
      wr(a_st, 32'h00000000);
      repeat (50) @(posedge ref_clk);
      rd(a_hi, d); chk("hi_again", 32'h0, d);
      rd(a_hi + 8'h01, d); chk("lo_latched", 32'h0, d);
      rd(a_hi + 8'h01, d); chkr("lo_live", 50, 90, d);
      $display("latch test done");
    end
  endtask

  task t_pre;
    begin
      for (s = 0; s < 7; s = s + 1) begin
        wr(a_st, {29'h6, s[2:0]});
        rd(a_st, d); chk("halt_crst", {29'h4, s[2:0]}, d);
        rc(v); chk("cleared", 32'h0, {16'h0, v});
        wr(a_st, {29'h0, s[2:0]});
        repeat (64 << s) @(posedge ref_clk);
        wr(a_st, {29'h4, s[2:0]});
        rc(v); chkr("prescale", 63, 67, {16'h0, v});
      end
      $display("prescaler test done");
    end
  endtask

  task t_ext;
    begin
      wr(a_st, 32'h00000037);
      wr(a_st, 32'h00000007);
      for (s = 0; s < 10; s = s + 1) pulse(0);
      chk("force_in", 32'h1, {31'h0, force_in});
      wr(a_st, 32'h00000027);
      rc(v); chk("ext_count", 32'h0000000a, {16'h0, v});
      wr(a_st, 32'h00000020);
      rc(v); chk("force_off", 32'h0, {31'h0, force_in});
      $display("external clock test done");
    end
  endtask

  task t_wrap;
    begin
      wr(a_st, 32'h00000070);
      wr(a_wh, 32'h00000000);
      wr(a_st, 32'h00000040);
      repeat (320) @(posedge ref_clk);
      rd(a_st, d); chk("ovf_blocked", 32'h00000040, d);
      chk("irq_blocked", 32'h0, {31'h0, ovf_irq});
      wr(a_st, 32'h00000070);
      wr(a_wl, 32'h00000003);
      wr(a_st, 32'h00000040);
      repeat (8) @(posedge ref_clk);
      rd(a_st, d); chk("ovf_set", 32'h000000c0, d);
      chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
      rc(v); chkr("wrapped", 0, 3, {16'h0, v});
      $display("wrap test done");
    end
  endtask

  task t_clear;
    begin
      rd(a_st, d);
      wr(a_st, 32'h00000040);
      rd(a_st, d); chk("ovf_race", 32'h000000c0, d);
      wr(a_st, 32'h000000f6);
      rd(a_st, d); chk("ovf_w1", 32'h000000e6, d);
      wr(a_st, 32'h000000c6);
      wr(a_st, 32'h00000046);
      wr(a_st, 32'h00000066);
      rd(a_st, d); chk("ovf_clr", 32'h00000066, d);
      chk("irq_clr", 32'h0, {31'h0, ovf_irq});
      $display("flag clear test done");
    end
  endtask

  task t_chan;
    begin
      wr(a_st, 32'h00000030);
      wr(`TCP_IDX_CH_VAL0, 32'h00000002);
      wr(a_c0, 32'h00000050);
      wr(a_st, 32'h00000000);
      repeat (8) @(posedge ref_clk);
      rd(a_c0, d); chk("cmp_flag", 32'h000000d0, d);
      chk("ch_irq", 32'h1, {31'h0, ch_irq[0]});
      wr(a_c0, 32'h00000050);
      rd(a_c0, d); chk("cmp_race", 32'h000000d0, d);
      wr(a_st, 32'h00000036);
      wr(a_st, 32'h00000006);
      rd(a_c0, d);
      wr(a_c0, 32'h00000050);
      wr(a_st, 32'h00000026);
      rd(a_c0, d); chk("cmp_clr", 32'h00000050, d);
      chk("ch_irq_clr", 32'h0, {31'h0, ch_irq[0]});
      wr(a_c1, 32'h00000044);
      pulse(1);
      rd(a_c1, d); chk("cap_halted", 32'h00000044, d);
      wr(a_st, 32'h00000000);
      pulse(1);
      rd(a_c1, d); chk("cap_flag", 32'h000000c4, d);
      chk("cap_irq", 32'h1, {31'h0, ch_irq[1]});
      $display("channel test done");
    end
  endtask

  // ------------------------------------------------------------------
  // clock, main sequence, watchdog
  // ------------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_latch;
    t_pre;
    t_ext;
    t_wrap;
    t_clear;
    t_chan;
    final_report;
  end

  // four times the ten thousand cycles the run takes
  initial begin
    #4000000;
    n_errors = n_errors + 1;
    final_report;
  end
endmodule
